/* File: hw/ebcs_pkg.sv */
// ebcs_pkg: register map, field layout and phase type of the bus cycle sequencer
package ebcs_pkg;
   // bus widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int REG_AW = 3;
   localparam int REG_DW = 32;
   // register indices on the plain register port
   localparam logic [2:0] REG_TIMING = 3'h0;
   localparam logic [2:0] REG_ADDR = 3'h1;
   localparam logic [2:0] REG_WDATA = 3'h2;
   localparam logic [2:0] REG_CMD = 3'h3;
   localparam logic [2:0] REG_RDATA = 3'h4;
   // chip_select_timing_config fields
   localparam int F_AB_LONG = 0;
   localparam int F_AB_EXT = 1;
   localparam int F_CMD_DLY = 3;
   localparam int F_WSETUP = 5;
   localparam int F_ACCESS = 6;
   localparam int F_HOLD = 11;
   localparam int F_RDY_EN = 13;
   localparam int F_RDY_POL = 14;
   localparam int F_RDY_ASYNC = 15;
   localparam int F_MUX = 16;
   localparam int TIMING_W = 17;
   localparam logic [16:0] TIMING_RST = 17'h00000;
   // command write fields
   localparam int F_START = 0;
   localparam int F_WRITE = 1;
   localparam int F_HBE = 2;
   // status read fields
   localparam int F_BUSY = 0;
   localparam int F_DONE = 1;
   localparam int F_RDY_LVL = 2;
   localparam int F_WAITS = 8;
   // address window compared for the address setup extension
   localparam int WIN_LO = 20;
   localparam int WIN_W = 4;
   // reset values of the data registers
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [15:0] DATA_RST = 16'h0000;
   // one bus_timing_unit is one sys_clk cycle
   localparam logic [4:0] UNIT_ONE = 5'h01;
   // cycle phases, gray coded along idle-ab-c-d-e-f
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_AB = 3'b001,
      PH_CMD = 3'b011,
      PH_WSET = 3'b010,
      PH_ACC = 3'b110,
      PH_HOLD = 3'b111
   } ebcs_phase_t;
endpackage : ebcs_pkg

/* File: hw/ebcs_ready_sync.sv */
// ebcs_ready_sync: direct and synchronised sampling of the handshake pin
module ebcs_ready_sync (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic readyPin,
   output logic syncSample,
   output logic asyncLevel
);
   logic direct_q, direct_d;
   logic [2:0] chain_q, chain_d;
   logic level_q, level_d;

   // sync mode takes one input register; async mode waits for two later stages to agree
   always_comb
   begin
      direct_d = readyPin;
      chain_d = {chain_q[1:0], readyPin};
      level_d = (chain_q[1] == chain_q[2]) ? chain_q[2] : level_q;
   end

   // stage 0 feeds only stage 1, so no logic sees a metastable value
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         direct_q <= 1'b0;
         chain_q <= 3'h0;
         level_q <= 1'b0;
      end
      else
      begin
         direct_q <= direct_d;
         chain_q <= chain_d;
         level_q <= level_d;
      end
   end

   assign syncSample = direct_q;
   assign asyncLevel = level_q;
endmodule : ebcs_ready_sync

/* File: hw/ebcs_sequencer.sv */
// ebcs_sequencer: five-phase external bus cycle engine with handshake extension
// Behaviour
// - every cycle runs address setup, command delay, write setup, access, hold in order, skipping command, write setup and hold at zero length
// - phase lengths come from the software timing register
// - address setup is 1 or 2 units, plus 0..3 when the window changes
// - command 0..3, write setup 0..1, access 1..32, hold 0..3 units
// - the handshake input may optionally stretch the access phase
// - a config bit selects active high or active low handshake
// - synchronous mode samples the handshake directly; partner drives it on the clock
// - asynchronous mode adds a synchroniser that sees the handshake three cycles after the sync sample would
// - the first sample point follows the cycle's programmed phase lengths
// - handshake inactive at a sample point inserts one wait state
// - handshake active at a sample point ends access and finishes the cycle
// - sync and async modes sample at different points, async later
// - the handshake is only looked at after the minimum access length
// - read data is captured on the edge that raises the read strobe
// - later address changes cannot disturb the captured read data
// - separate mode uses 24 address and 16 data lines; muxed shares 16 lines
// - the reference clock output is the system clock
module ebcs_sequencer (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [ebcs_pkg::REG_AW-1:0] regAddr,
   input wire logic [ebcs_pkg::REG_DW-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [ebcs_pkg::REG_DW-1:0] regRdata,
   output logic [ebcs_pkg::ADDR_W-1:0] addressLines,
   input wire logic [ebcs_pkg::DATA_W-1:0] dataLinesIn,
   output logic [ebcs_pkg::DATA_W-1:0] dataLinesOut,
   output logic dataLinesOe,
   input wire logic [ebcs_pkg::DATA_W-1:0] muxedAddrDataBusIn,
   output logic [ebcs_pkg::DATA_W-1:0] muxedAddrDataBusOut,
   output logic muxedAddrDataBusOe,
   output logic addrLatch,
   output logic chipSelectN,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic highByteEnableN,
   input wire logic readyIn,
   output logic referenceClockOutput
);
   import ebcs_pkg::*;

   // skip phases programmed to zero length
   function automatic ebcs_phase_t skipEmpty(ebcs_phase_t ph, logic [TIMING_W-1:0] t);
      ebcs_phase_t r;
      r = ph;
      if (r == PH_CMD && t[F_CMD_DLY +: 2] == 2'h0) r = PH_WSET;
      if (r == PH_WSET && !t[F_WSETUP]) r = PH_ACC;
      if (r == PH_HOLD && t[F_HOLD +: 2] == 2'h0) r = PH_IDLE;
      return r;
   endfunction : skipEmpty

   // units left after the first one, loaded on phase entry
   function automatic logic [4:0] phaseCount(ebcs_phase_t ph, logic [TIMING_W-1:0] t);
      logic [4:0] r;
      case (ph)
         PH_CMD: r = {3'h0, t[F_CMD_DLY +: 2]} - UNIT_ONE;
         PH_ACC: r = t[F_ACCESS +: 5];
         PH_HOLD: r = {3'h0, t[F_HOLD +: 2]} - UNIT_ONE;
         default: r = 5'h00;
      endcase
      return r;
   endfunction : phaseCount

   // programming and data registers
   logic [TIMING_W-1:0] timing_q, timing_d;
   logic [ADDR_W-1:0] addrReg_q, addrReg_d;
   logic [DATA_W-1:0] wdataReg_q, wdataReg_d;
   logic [REG_DW-1:0] rdOut_q, rdOut_d;
   logic done_q, done_d;
   // running cycle
   ebcs_phase_t state_q, state_d;
   logic [4:0] cnt_q, cnt_d;
   logic [TIMING_W-1:0] cyc_q, cyc_d;
   logic [ADDR_W-1:0] cycAddr_q, cycAddr_d;
   logic [DATA_W-1:0] cycData_q, cycData_d;
   logic write_q, write_d;
   logic hbe_q, hbe_d;
   logic [WIN_W-1:0] prevWin_q, prevWin_d;
   logic winValid_q, winValid_d;
   logic [7:0] waits_q, waits_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   // pin flops
   logic csN_q, csN_d, ale_q, ale_d, rdN_q, rdN_d, wrN_q, wrN_d, hbeN_q, hbeN_d;
   logic muxOe_q, muxOe_d, dataOe_q, dataOe_d;
   logic [DATA_W-1:0] muxOut_q, muxOut_d;
   // handshake and start decode
   logic syncSample, asyncLevel, rdyLevel, rdyActive, startReq, winChanged;
   logic [4:0] abCount;
   logic [DATA_W-1:0] readBus;

   ebcs_ready_sync u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .readyPin(readyIn),
      .syncSample(syncSample),
      .asyncLevel(asyncLevel)
   );

   // async uses the synchronised level, so its sample point falls later
   assign rdyLevel = cyc_q[F_RDY_ASYNC] ? asyncLevel : syncSample;
   assign rdyActive = (rdyLevel == cyc_q[F_RDY_POL]);
   assign startReq = regWr && regAddr == REG_CMD && regWdata[F_START] && state_q == PH_IDLE;
   assign winChanged = !winValid_q || addrReg_q[WIN_LO +: WIN_W] != prevWin_q;
   // address setup: 1 or 2 units, plus 0..3 on a new window, loaded as units-1
   assign abCount = {4'h0, timing_q[F_AB_LONG]}
      + (winChanged ? {3'h0, timing_q[F_AB_EXT +: 2]} : 5'h00);
   assign readBus = cyc_q[F_MUX] ? muxedAddrDataBusIn : dataLinesIn;

   // register port: writes steer the block, reads show its state one cycle later
   always_comb
   begin
      timing_d = timing_q;
      addrReg_d = addrReg_q;
      wdataReg_d = wdataReg_q;
      rdOut_d = '0;
      // set wins: a finishing cycle outranks the clear made by a new start
      done_d = (done_q && !startReq) || (state_q != PH_IDLE && state_d == PH_IDLE);
      if (regWr)
      begin
         case (regAddr)
            REG_TIMING: timing_d = regWdata[TIMING_W-1:0];
            REG_ADDR: addrReg_d = regWdata[ADDR_W-1:0];
            REG_WDATA: wdataReg_d = regWdata[DATA_W-1:0];
            default: ;
         endcase
      end
      if (regRd)
      begin
         case (regAddr)
            REG_TIMING: rdOut_d = {{(REG_DW-TIMING_W){1'b0}}, timing_q};
            REG_ADDR: rdOut_d = {{(REG_DW-ADDR_W){1'b0}}, addrReg_q};
            REG_WDATA: rdOut_d = {{(REG_DW-DATA_W){1'b0}}, wdataReg_q};
            REG_CMD: rdOut_d = {16'h0000, waits_q, 5'h00, rdyLevel, done_q,
               state_q != PH_IDLE};
            REG_RDATA: rdOut_d = {{(REG_DW-DATA_W){1'b0}}, rdata_q};
            default: rdOut_d = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timing_q <= TIMING_RST;
         addrReg_q <= ADDR_RST;
         wdataReg_q <= DATA_RST;
         rdOut_q <= '0;
         done_q <= 1'b0;
      end
      else
      begin
         timing_q <= timing_d;
         addrReg_q <= addrReg_d;
         wdataReg_q <= wdataReg_d;
         rdOut_q <= rdOut_d;
         done_q <= done_d;
      end
   end

   // phase sequencer; the timing is frozen at start so a rewrite cannot bend a running cycle
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      cyc_d = cyc_q;
      cycAddr_d = cycAddr_q;
      cycData_d = cycData_q;
      write_d = write_q;
      hbe_d = hbe_q;
      prevWin_d = prevWin_q;
      winValid_d = winValid_q;
      waits_d = waits_q;
      rdata_d = rdata_q;
      case (state_q)
         PH_IDLE:
         begin
            if (startReq)
            begin
               state_d = PH_AB;
               cnt_d = abCount;
               cyc_d = timing_q;
               cycAddr_d = addrReg_q;
               cycData_d = wdataReg_q;
               write_d = regWdata[F_WRITE];
               hbe_d = regWdata[F_HBE];
               prevWin_d = addrReg_q[WIN_LO +: WIN_W];
               winValid_d = 1'b1;
               waits_d = 8'h00;
            end
         end
         PH_AB, PH_CMD, PH_WSET:
         begin
            if (cnt_q != 5'h00)
               cnt_d = cnt_q - UNIT_ONE;
            else
            begin
               // sample point placed by the lengths of this very cycle
               state_d = (state_q == PH_AB) ? skipEmpty(PH_CMD, cyc_q)
                  : (state_q == PH_CMD) ? skipEmpty(PH_WSET, cyc_q) : PH_ACC;
               cnt_d = phaseCount(state_d, cyc_q);
            end
         end
         PH_ACC:
         begin
            if (cnt_q != 5'h00)
               cnt_d = cnt_q - UNIT_ONE;
            else if (!cyc_q[F_RDY_EN] || rdyActive)
            begin
               state_d = skipEmpty(PH_HOLD, cyc_q);
               cnt_d = phaseCount(state_d, cyc_q);
               // latched on the strobe's rising edge, later address moves are harmless
               if (!write_q)
                  rdata_d = readBus;
            end
            else if (waits_q != 8'hff)
               waits_d = waits_q + 8'h01;
         end
         PH_HOLD:
         begin
            if (cnt_q != 5'h00)
               cnt_d = cnt_q - UNIT_ONE;
            else
               state_d = PH_IDLE;
         end
         default: state_d = PH_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= PH_IDLE;
         cnt_q <= 5'h00;
         cyc_q <= TIMING_RST;
         cycAddr_q <= ADDR_RST;
         cycData_q <= DATA_RST;
         write_q <= 1'b0;
         hbe_q <= 1'b0;
         prevWin_q <= '0;
         winValid_q <= 1'b0;
         waits_q <= 8'h00;
         rdata_q <= DATA_RST;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cyc_q <= cyc_d;
         cycAddr_q <= cycAddr_d;
         cycData_q <= cycData_d;
         write_q <= write_d;
         hbe_q <= hbe_d;
         prevWin_q <= prevWin_d;
         winValid_q <= winValid_d;
         waits_q <= waits_d;
         rdata_q <= rdata_d;
      end
   end

   // pin controls follow the next phase, so every strobe edge sits on a phase boundary
   always_comb
   begin
      csN_d = (state_d == PH_IDLE);
      ale_d = (state_d == PH_AB);
      rdN_d = !(!write_d && (state_d == PH_WSET || state_d == PH_ACC));
      wrN_d = !(write_d && state_d == PH_ACC);
      hbeN_d = !(hbe_d && state_d != PH_IDLE);
      // muxed: address in setup and delay, then write data or released for reading
      muxOe_d = cyc_d[F_MUX] && (state_d == PH_AB || state_d == PH_CMD
         || (write_d && (state_d == PH_WSET || state_d == PH_ACC || state_d == PH_HOLD)));
      muxOut_d = (state_d == PH_AB || state_d == PH_CMD) ? cycAddr_d[DATA_W-1:0] : cycData_d;
      dataOe_d = !cyc_d[F_MUX] && write_d
         && (state_d == PH_WSET || state_d == PH_ACC || state_d == PH_HOLD);
   end

   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         csN_q <= 1'b1;
         ale_q <= 1'b0;
         rdN_q <= 1'b1;
         wrN_q <= 1'b1;
         hbeN_q <= 1'b1;
         muxOe_q <= 1'b0;
         muxOut_q <= DATA_RST;
         dataOe_q <= 1'b0;
      end
      else
      begin
         csN_q <= csN_d;
         ale_q <= ale_d;
         rdN_q <= rdN_d;
         wrN_q <= wrN_d;
         hbeN_q <= hbeN_d;
         muxOe_q <= muxOe_d;
         muxOut_q <= muxOut_d;
         dataOe_q <= dataOe_d;
      end
   end

   assign regRdata = rdOut_q;
   assign addressLines = cycAddr_q;
   assign dataLinesOut = cycData_q;
   assign dataLinesOe = dataOe_q;
   assign muxedAddrDataBusOut = muxOut_q;
   assign muxedAddrDataBusOe = muxOe_q;
   assign addrLatch = ale_q;
   assign chipSelectN = csN_q;
   assign readStrobeN = rdN_q;
   assign writeStrobeN = wrN_q;
   assign highByteEnableN = hbeN_q;
   // partner times its synchronous handshake against this copy of the clock
   assign referenceClockOutput = sys_clk;

   // checks on phase order, timing and pins
   a_phase_order:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      ($past(state_q) == PH_AB && state_q != PH_AB)
      |-> state_q inside {PH_CMD, PH_WSET, PH_ACC})
   else $error("address setup left to a wrong phase");

   a_ab_short:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (startReq && abCount == 5'h00) |=> state_q == PH_AB ##1 state_q != PH_AB)
   else $error("one-unit address setup not one cycle");

   a_access_min:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_q == PH_ACC && cnt_q != 5'h00) |=> state_q == PH_ACC && !$changed(waits_q))
   else $error("access ended or waited before its minimum");

   a_ready_wait:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_q == PH_ACC && cnt_q == 5'h00 && cyc_q[F_RDY_EN] && !rdyActive
         && waits_q != 8'hff)
      |=> state_q == PH_ACC && waits_q == $past(waits_q) + 8'h01)
   else $error("inactive handshake did not insert a wait state");

   a_ready_end:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_q == PH_ACC && cnt_q == 5'h00 && rdyActive) |=> state_q != PH_ACC)
   else $error("active handshake did not end access");

   a_read_capture:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (state_q == PH_ACC && state_d != PH_ACC && !write_q)
      |=> $rose(readStrobeN) && rdata_q == $past(readBus))
   else $error("read data not taken on strobe rise");

   a_async_delay:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(asyncLevel) |-> $past(readyIn, 4) && $past(readyIn, 3))
   else $error("synchronised handshake too early");

   a_strobe_frame:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (addrLatch || !readStrobeN || !writeStrobeN) |-> !chipSelectN && !(addrLatch
         && (!readStrobeN || !writeStrobeN)))
   else $error("strobe outside chip select or overlapping latch");

   a_mux_address:
   assert property (@(posedge sys_clk) disable iff (!rstn)
      (cyc_q[F_MUX] && addrLatch) |-> muxedAddrDataBusOe && !dataLinesOe
         && muxedAddrDataBusOut == addressLines[DATA_W-1:0])
   else $error("muxed address not driven during latch");
endmodule : ebcs_sequencer

/* File: verif/ebcs_mem_model.sv */
// ebcs_mem_model: external memory partner with a handshake output
module ebcs_mem_model (
   input wire logic sys_clk,
   input wire logic [23:0] addressLines,
   input wire logic [15:0] dataLinesOut,
   input wire logic dataLinesOe,
   input wire logic [15:0] muxedAddrDataBusOut,
   input wire logic muxedAddrDataBusOe,
   input wire logic addrLatch,
   input wire logic readStrobeN,
   input wire logic writeStrobeN,
   input wire logic muxMode,
   input wire logic rdyHigh,
   input wire logic [7:0] rdyDelay,
   output logic [15:0] dataLinesIn,
   output logic [15:0] muxedAddrDataBusIn,
   output logic readyIn,
   output logic [15:0] lastWrite
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] loAddr = 16'h0;
   logic [15:0] lastD = 16'h0;
   logic [15:0] lastM = 16'h0;
   logic [7:0] age = 8'h0;
   logic [23:0] acc;
   logic [15:0] rdData;
   logic strobe;
   // muxed mode rebuilds the address from the latched low half
   assign acc = muxMode ? {addressLines[23:16], loAddr} : addressLines;
   assign rdData = acc[15:0] ^ {acc[23:16], 8'h5a};
   assign strobe = !readStrobeN || !writeStrobeN;
   // held until the strobe rises, far over one clock, then dropped
   assign readyIn = (strobe && age >= rdyDelay) ? rdyHigh : !rdyHigh;
   // released lines show the inverted last level, so stale data cannot pass
   assign dataLinesIn = dataLinesOe ? dataLinesOut :
      (!muxMode && !readStrobeN) ? rdData : ~lastD;
   assign muxedAddrDataBusIn = muxedAddrDataBusOe ? muxedAddrDataBusOut :
      (muxMode && !readStrobeN) ? rdData : ~lastM;
   // strobe age drives the handshake delay; write data kept from the strobe
   always_ff @(posedge sys_clk)
   begin
      lastD <= dataLinesIn;
      lastM <= muxedAddrDataBusIn;
      age <= strobe ? age + 8'h01 : 8'h00;
      if (addrLatch)
         loAddr <= muxedAddrDataBusOut;
      if (!writeStrobeN)
         lastWrite <= muxMode ? muxedAddrDataBusIn : dataLinesIn;
   end
endmodule : ebcs_mem_model

/* File: verif/testbench.sv */
// testbench: self-checking bench for the external bus cycle sequencer
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ebcs_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] regAddr = 3'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic muxMode = 1'b0;
   logic rdyHigh = 1'b0;
   logic [7:0] rdyDelay = 8'h0;
   logic [31:0] regRdata;
   logic [23:0] addressLines;
   logic [15:0] dataLinesIn, dataLinesOut, muxedAddrDataBusIn, muxedAddrDataBusOut, lastWrite;
   logic dataLinesOe, muxedAddrDataBusOe, addrLatch, chipSelectN, readStrobeN;
   logic writeStrobeN, highByteEnableN, readyIn, referenceClockOutput;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int hbeLow = 0;
   logic [23:0] prevA;

   ebcs_sequencer DUT (.sys_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .addressLines, .dataLinesIn, .dataLinesOut, .dataLinesOe, .muxedAddrDataBusIn,
      .muxedAddrDataBusOut, .muxedAddrDataBusOe, .addrLatch, .chipSelectN, .readStrobeN,
      .writeStrobeN, .highByteEnableN, .readyIn, .referenceClockOutput);
   ebcs_mem_model mem (.sys_clk, .addressLines, .dataLinesOut, .dataLinesOe,
      .muxedAddrDataBusOut, .muxedAddrDataBusOe, .addrLatch, .readStrobeN, .writeStrobeN,
      .muxMode, .rdyHigh, .rdyDelay, .dataLinesIn, .muxedAddrDataBusIn, .readyIn, .lastWrite);

   // 250 MHz system clock
   always #2 sys_clk = ~sys_clk;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic regWrite(input logic [2:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : regWrite

   // read data stands only in the cycle after the strobe
   task automatic regRead(input logic [2:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask : regRead

   function automatic logic [31:0] mkT(input int abl, ext, cmd, ws, acc, hold, en, pol, asy, mx);
      logic [31:0] t;
      t = 32'h0;
      t[F_AB_LONG] = abl[0];
      t[F_AB_EXT +: 2] = ext[1:0];
      t[F_CMD_DLY +: 2] = cmd[1:0];
      t[F_WSETUP] = ws[0];
      t[F_ACCESS +: 5] = 5'(acc - 1);
      t[F_HOLD +: 2] = hold[1:0];
      t[F_RDY_EN] = en[0];
      t[F_RDY_POL] = pol[0];
      t[F_RDY_ASYNC] = asy[0];
      t[F_MUX] = mx[0];
      return t;
   endfunction : mkT

   function automatic logic [31:0] memVal(input logic [23:0] a);
      return {16'h0, a[15:0] ^ {a[23:16], 8'h5a}};
   endfunction : memVal

   task automatic setup(input logic [31:0] t, input logic [23:0] a);
      regWrite(REG_TIMING, t);
      regWrite(REG_ADDR, {8'h0, a});
      muxMode <= t[F_MUX];
      rdyHigh <= t[F_RDY_POL];
   endtask : setup

   // counts strobe cycles from the start command until chip select returns high
   task automatic runCycle(input logic [2:0] cmd, output int cs, output int rd, output int wr);
      cs = 0;
      rd = 0;
      wr = 0;
      hbeLow = 0;
      regWrite(REG_CMD, {29'h0, cmd});
      for (int i = 0; i < 300; i++)
      begin
         #1;
         cs += int'(chipSelectN === 1'b0);
         rd += int'(readStrobeN === 1'b0);
         wr += int'(writeStrobeN === 1'b0);
         hbeLow += int'(highByteEnableN === 1'b0);
         if (cs > 0 && chipSelectN === 1'b1)
            break;
         @(posedge sys_clk);
      end
   endtask : runCycle

   task automatic finishRead(input logic [23:0] a, output logic [7:0] w);
      logic [31:0] d;
      regRead(REG_CMD, d);
      check("status done", 32'h2, {30'h0, d[1:0]});
      w = d[15:8];
      regRead(REG_RDATA, d);
      check("read data", memVal(a), d);
      prevA = a;
   endtask : finishRead

   task automatic testReset();
      logic [31:0] d;
      check("chip select idle", 32'h1, {31'h0, chipSelectN});
      regRead(REG_TIMING, d);
      check("timing reset", 32'h0, d);
      regWrite(3'h6, 32'hffffffff);
      regRead(3'h5, d);
      check("unmapped read", 32'h0, d);
      regRead(REG_TIMING, d);
      check("timing kept", 32'h0, d);
      // let the continuous copy settle before comparing
      @(negedge sys_clk);
      #1;
      check("reference clock", {31'h0, sys_clk}, {31'h0, referenceClockOutput});
      $display("test reset done");
   endtask : testReset

   task automatic testBasic(input int mx, input logic [23:0] a);
      int cs, rd, wr;
      logic [7:0] w;
      setup(mkT(0, 0, 0, 0, 1, 0, 0, 0, 0, mx), a);
      runCycle(3'b001, cs, rd, wr);
      check("cycle length", 32'd2, 32'(cs));
      check("read strobe", 32'd1, 32'(rd));
      check("write strobe", 32'd0, 32'(wr));
      check("byte enable idle", 32'd0, 32'(hbeLow));
      check("address", {8'h0, a}, {8'h0, addressLines});
      finishRead(a, w);
      $display("test basic read done");
   endtask : testBasic

   task automatic testWrite();
      int cs, rd, wr;
      logic [31:0] d;
      setup(mkT(1, 3, 3, 1, 32, 3, 0, 0, 0, 0), 24'h5b0ff0);
      regWrite(REG_WDATA, 32'h0000c3a5);
      runCycle(3'b111, cs, rd, wr);
      check("write cycle length", 32'd44, 32'(cs));
      check("write strobe", 32'd32, 32'(wr));
      check("byte enable", 32'd44, 32'(hbeLow));
      check("read strobe", 32'd0, 32'(rd));
      check("written data", 32'h0000c3a5, {16'h0, lastWrite});
      regRead(REG_RDATA, d);
      check("read data kept", memVal(prevA), d);
      // muxed write: data must reach the shared lines during access
      setup(mkT(0, 0, 0, 0, 1, 0, 0, 0, 0, 1), 24'h5b1234);
      regWrite(REG_WDATA, 32'h00003c96);
      runCycle(3'b011, cs, rd, wr);
      check("mux write length", 32'd2, 32'(cs));
      check("mux write strobe", 32'd1, 32'(wr));
      check("mux written data", 32'h00003c96, {16'h0, lastWrite});
      $display("test write done");
   endtask : testWrite

   task automatic testWindow();
      int cs, rd, wr;
      setup(mkT(0, 2, 1, 0, 2, 1, 0, 0, 0, 0), 24'h5a0001);
      runCycle(3'b001, cs, rd, wr);
      check("same window", 32'd5, 32'(cs));
      check("access strobe", 32'd2, 32'(rd));
      setup(mkT(0, 2, 1, 0, 2, 1, 0, 0, 0, 0), 24'h9a0001);
      runCycle(3'b001, cs, rd, wr);
      check("new window", 32'd7, 32'(cs));
      $display("test window done");
   endtask : testWindow

   // wait count kept four-state so an unknown status cannot pass as zero
   task automatic rdyRun(input int asy, input int pol, input logic [7:0] dly,
      output logic [7:0] w);
      int cs, rd, wr;
      setup(mkT(0, 0, 0, 0, 3, 0, 1, pol, asy, 0), 24'h9a0102);
      rdyDelay <= dly;
      runCycle(3'b001, cs, rd, wr);
      finishRead(24'h9a0102, w);
      check("strobe vs waits", 32'(3 + w), 32'(rd));
   endtask : rdyRun

   task automatic testHandshake();
      logic [7:0] w0, w1, w2, w3, w4;
      rdyRun(0, 1, 8'd0, w0);
      check("sync no wait", 32'd0, 32'(w0));
      rdyRun(1, 1, 8'd0, w1);
      check("async extra wait", 32'd1, 32'(w1 >= 1));
      rdyRun(0, 1, 8'd5, w2);
      check("sync waits", 32'd1, 32'(w2 > 0));
      rdyRun(0, 0, 8'd5, w3);
      check("low polarity", 32'(w2), 32'(w3));
      rdyRun(1, 1, 8'd5, w4);
      check("async later", 32'd1, 32'(w4 > w2));
      $display("test handshake done");
   endtask : testHandshake

   // hang guard well above the few hundred cycles the tests need
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         $display("ERROR timeout expected end seen %0d cycles", cycles);
         summarize();
      end
   end

   initial
   begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      testReset();
      testBasic(0, 24'h3a5c17);
      testBasic(1, 24'hc1e2d4);
      testWrite();
      testWindow();
      testHandshake();
      summarize();
   end
endmodule : testbench
